// *** core/psf_pkg.sv ***
// Constants for the synthesizer control and clock status flag block
// How it works
// - Multiplier write needs protect clear, synth selected
// - Accepted multiplier write clears settled, qualified
// - VCO equals two times reference times multiplier+1
// - Divider write gated; accepted write clears status
// - Reference is oscillator/(divider+1) or internal 1M
// - Oscillator off forces lowest loop filter range
// - Output divider write needs synth clock selected
// - Synth is VCO/(div+1) settled, else VCO/4
// - Bus clock is half synth when selected
// - Tick flag sets per period, write-one clears
// - Power-on flag set by power-on, write-one clears
// - Brown-out flag set by brownout or power-on
// - Settle-change flag sets on settled edge
// - Settled bit is read-only status
// - Bad-address flag sets on event, power-on clears
// - Osc-change flag sets on qualified change
// - Qualified cleared on full stop, gates CAN clock
// - Losing settle clears qualified except pseudo stop
// - Synth select forced when unqualified or full stop
package psf_pkg;
  localparam logic [3:0] ADDR_SYNTH_MULT = 4'h0;
  localparam logic [3:0] ADDR_REF_DIV    = 4'h1;
  localparam logic [3:0] ADDR_OUT_DIV    = 4'h2;
  localparam logic [3:0] ADDR_FLAGS      = 4'h3;
  localparam logic [3:0] ADDR_CTRL       = 4'h4;
  localparam logic [3:0] ADDR_RATIO      = 4'h5;
  // Multiplier register fields
  localparam int MULT_LSB = 0;
  localparam int MULT_W   = 6;
  localparam int VCOR_LSB = 6;
  // Reference and output divider register fields
  localparam int REFD_LSB = 0;
  localparam int REFD_W   = 4;
  localparam int REFR_LSB = 6;
  localparam int OUTD_W   = 5;
  // Flag bit positions
  localparam int FLG_TICK    = 7;
  localparam int FLG_POR     = 6;
  localparam int FLG_BROWN   = 5;
  localparam int FLG_SETCHG  = 4;
  localparam int FLG_SETTLED = 3;
  localparam int FLG_BADADR  = 2;
  localparam int FLG_OSCCHG  = 1;
  localparam int FLG_QUAL    = 0;
  // Control register bit positions
  localparam int CTL_WRITE_PROTECT_BIT = 0;
  localparam int CTL_SEL  = 1;
  localparam int CTL_EXT_OSC_ENABLE = 2;
  // Reset values
  localparam logic [7:0] RST_SYNTH_MULT = 8'h00;
  localparam logic [7:0] RST_REF_DIV    = 8'h00;
  localparam logic [4:0] RST_OUT_DIV    = 5'h03;
  localparam logic [1:0] REF_RANGE_LOW  = 2'h0;
  localparam logic [6:0] UNSETTLED_DIV  = 7'h04;
  localparam logic [6:0] BUS_RATIO      = 7'h02;
endpackage

// *** core/psf_synth_status.sv ***
// Synthesizer control registers and clock status flags
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module psf_synth_status
(
  // Clock and resets
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_poweron,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output var  logic [7:0] o_rdata,
  // Events and status from the analog loop
  input  wire logic       i_tick_event,
  input  wire logic       i_brownout_event,
  input  wire logic       i_bad_address_event,
  input  wire logic       i_loop_in_tol,
  input  wire logic       i_osc_good,
  input  wire logic       i_full_stop,
  input  wire logic       i_pseudo_stop,
  // Loop settings out
  output var  logic [5:0] o_loop_multiplier,
  output var  logic [1:0] o_vco_range_sel,
  output var  logic [3:0] o_ref_divider,
  output var  logic [1:0] o_ref_range_eff,
  output var  logic [4:0] o_output_divider,
  output var  logic [6:0] o_synth_div_eff,
  output var  logic       o_ref_from_osc,
  output var  logic       o_synth_clock_select,
  output var  logic       o_can_osc_clk_en,
  output var  logic [3:0] o_irq_req
);
  typedef struct packed {
    logic [7:0] mult;
    logic [7:0] refd;
    logic [4:0] outd;
    logic       tick, por, brown, setchg, settled, badadr, oscchg, qual;
    logic       write_protect_bit, sel, ext_osc_enable;
    logic [2:0] irq_en;
    logic [7:0] rdata;
    logic [1:0] rre;    // Filter range actually applied
    logic [6:0] dive;   // Effective synth divide
    logic [3:0] irq;    // Interrupt requests
  } psf_state_type;

  psf_state_type r;
  psf_state_type next_r;

  // Write-one clear that loses to a simultaneous set
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  logic wr_flags;
  logic gate_ok;
  logic loop_wr;
  logic new_settled;
  logic new_qual;
  logic [7:0] rd_mux;

  // Next state of all registers
  always_comb
  begin
    next_r   = r;
    wr_flags = i_wr && (i_addr == psf_pkg::ADDR_FLAGS);
    gate_ok  = ~r.write_protect_bit & r.sel;
    loop_wr  = i_wr && gate_ok &&
               (i_addr == psf_pkg::ADDR_SYNTH_MULT || i_addr == psf_pkg::ADDR_REF_DIV);
    if (i_wr && gate_ok && i_addr == psf_pkg::ADDR_SYNTH_MULT)
      next_r.mult = i_wdata;
    if (i_wr && gate_ok && i_addr == psf_pkg::ADDR_REF_DIV)
      next_r.refd = i_wdata;
    if (i_wr && r.sel && i_addr == psf_pkg::ADDR_OUT_DIV)
      next_r.outd = i_wdata[psf_pkg::OUTD_W-1:0];
    if (i_wr && i_addr == psf_pkg::ADDR_CTRL)
    begin
      next_r.write_protect_bit   = i_wdata[psf_pkg::CTL_WRITE_PROTECT_BIT];
      next_r.ext_osc_enable   = i_wdata[psf_pkg::CTL_EXT_OSC_ENABLE];
      next_r.irq_en = i_wdata[7:5];
      // Clearing select needs a qualified oscillator
      next_r.sel    = i_wdata[psf_pkg::CTL_SEL] | ~r.qual;
    end
    // Settled and qualified status; loop writes restart both
    new_settled = i_loop_in_tol & ~loop_wr;
    new_qual    = i_osc_good & ~loop_wr & ~i_full_stop;
    if (r.settled && !new_settled && !i_pseudo_stop)
      new_qual = 1'b0;
    next_r.settled = new_settled;
    next_r.qual    = new_qual;
    if (!new_qual || i_full_stop)
      next_r.sel = 1'b1;
    // Sticky flags, set dominates clear
    next_r.tick   = sticky(r.tick, i_tick_event,
                           wr_flags & i_wdata[psf_pkg::FLG_TICK]);
    next_r.por    = sticky(r.por, 1'b0, wr_flags & i_wdata[psf_pkg::FLG_POR]);
    next_r.brown  = sticky(r.brown, i_brownout_event,
                           wr_flags & i_wdata[psf_pkg::FLG_BROWN]);
    next_r.setchg = sticky(r.setchg, new_settled ^ r.settled,
                           wr_flags & i_wdata[psf_pkg::FLG_SETCHG]);
    next_r.badadr = sticky(r.badadr, i_bad_address_event,
                           wr_flags & i_wdata[psf_pkg::FLG_BADADR]);
    next_r.oscchg = sticky(r.oscchg, new_qual ^ r.qual,
                           wr_flags & i_wdata[psf_pkg::FLG_OSCCHG]);
    // Read mux, data one cycle later
    case (i_addr)
      psf_pkg::ADDR_SYNTH_MULT: rd_mux = r.mult;
      psf_pkg::ADDR_REF_DIV:    rd_mux = {r.refd[7:6], 2'b00, r.refd[3:0]};
      psf_pkg::ADDR_OUT_DIV:    rd_mux = {3'b000, r.outd};
      psf_pkg::ADDR_FLAGS:      rd_mux = {r.tick, r.por, r.brown, r.setchg,
                                          r.settled, r.badadr, r.oscchg, r.qual};
      psf_pkg::ADDR_CTRL:       rd_mux = {r.irq_en, 2'b00, r.ext_osc_enable, r.sel, r.write_protect_bit};
      psf_pkg::ADDR_RATIO:      rd_mux = {1'b0, psf_pkg::BUS_RATIO};
      default:                  rd_mux = 8'h00;
    endcase
    next_r.rdata = i_rd ? rd_mux : 8'h00;
    // Derived outputs registered so every output leaves a flip-flop
    next_r.rre  = next_r.ext_osc_enable ? next_r.refd[psf_pkg::REFR_LSB +: 2]
                              : psf_pkg::REF_RANGE_LOW;
    next_r.dive = next_r.settled ? {2'b00, next_r.outd} + 7'h01
                                 : psf_pkg::UNSETTLED_DIV;
    next_r.irq  = {next_r.tick & next_r.irq_en[2], next_r.setchg & next_r.irq_en[1],
                   next_r.oscchg & next_r.irq_en[0], 1'b0};
  end

  // State register; power-on sets the power-on and brown-out flags and clears the bad-address flag
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      r      <= '0;
      r.mult <= psf_pkg::RST_SYNTH_MULT;
      r.refd <= psf_pkg::RST_REF_DIV;
      r.outd <= psf_pkg::RST_OUT_DIV;
      r.sel  <= 1'b1;
      r.write_protect_bit <= 1'b0;
      r.dive <= psf_pkg::UNSETTLED_DIV;
    end
    else if (i_poweron)
    begin
      r       <= next_r;
      r.por   <= 1'b1;
      r.brown <= 1'b1;
      r.badadr <= 1'b0;
    end
    else
      r <= next_r;
  end

  // Outputs straight from the state register
  assign o_rdata              = r.rdata;
  assign o_loop_multiplier    = r.mult[psf_pkg::MULT_LSB +: psf_pkg::MULT_W];
  assign o_vco_range_sel      = r.mult[psf_pkg::VCOR_LSB +: 2];
  assign o_ref_divider        = r.refd[psf_pkg::REFD_LSB +: psf_pkg::REFD_W];
  assign o_ref_from_osc       = r.ext_osc_enable;
  assign o_ref_range_eff      = r.rre;
  assign o_output_divider     = r.outd;
  assign o_synth_div_eff      = r.dive;
  assign o_synth_clock_select = r.sel;
  assign o_can_osc_clk_en     = r.qual;
  assign o_irq_req            = r.irq;
endmodule
`default_nettype wire

// *** tb/psf_synth_status_monitor.sv ***
// Checker of write gating and clock status outputs of the synth status block
`timescale 1ns/100ps
`default_nettype none
module psf_synth_status_monitor
(
  // Clock, reset and register port
  input wire logic       i_clk, i_resetn, i_wr, i_rd, i_full_stop,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] o_rdata,
  // Loop settings and status
  input wire logic [5:0] o_loop_multiplier,
  input wire logic [3:0] o_ref_divider,
  input wire logic [1:0] o_ref_range_eff,
  input wire logic [4:0] o_output_divider,
  input wire logic [6:0] o_synth_div_eff,
  input wire logic       o_ref_from_osc, o_synth_clock_select, o_can_osc_clk_en
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // An accepted multiplier write, seen as the field changing a cycle later
  sequence s_mult_taken;
    i_wr && i_addr == psf_pkg::ADDR_SYNTH_MULT ##1 $changed(o_loop_multiplier);
  endsequence
  property p_mult_clears;
    s_mult_taken |-> !o_can_osc_clk_en && o_synth_div_eff == psf_pkg::UNSETTLED_DIV;
  endproperty
  a_mult_clears: assert property (p_mult_clears) else $error("status kept");
  property p_mult_gate;
    i_wr && i_addr == psf_pkg::ADDR_SYNTH_MULT && !o_synth_clock_select
      |=> $stable(o_loop_multiplier);
  endproperty
  a_mult_gate: assert property (p_mult_gate) else $error("multiplier taken");
  property p_refd_gate;
    i_wr && i_addr == psf_pkg::ADDR_REF_DIV && !o_synth_clock_select |=> $stable(o_ref_divider);
  endproperty
  a_refd_gate: assert property (p_refd_gate) else $error("divider taken");
  property p_outd_gate;
    i_wr && i_addr == psf_pkg::ADDR_OUT_DIV && !o_synth_clock_select
      |=> $stable(o_output_divider);
  endproperty
  a_outd_gate: assert property (p_outd_gate) else $error("post divider taken");
  property p_div_eff;
    o_synth_div_eff == 7'h04 || o_synth_div_eff == {2'h0, o_output_divider} + 7'h01;
  endproperty
  a_div_eff: assert property (p_div_eff) else $error("bad synth divide");
  property p_ref_range;
    !o_ref_from_osc |-> o_ref_range_eff == psf_pkg::REF_RANGE_LOW;
  endproperty
  a_ref_range: assert property (p_ref_range) else $error("filter range moved");
  property p_sel_forced;
    !o_can_osc_clk_en [*2] |-> o_synth_clock_select;
  endproperty
  a_sel_forced: assert property (p_sel_forced) else $error("select not forced");
  property p_ratio;
    i_rd && i_addr == psf_pkg::ADDR_RATIO |=> o_rdata == {1'b0, psf_pkg::BUS_RATIO};
  endproperty
  a_ratio: assert property (p_ratio) else $error("bus ratio wrong");
  property p_full_stop;
    $rose(i_full_stop) |-> ##[1:2] !o_can_osc_clk_en;
  endproperty
  a_full_stop: assert property (p_full_stop) else $error("qualified kept");
endmodule
bind psf_synth_status psf_synth_status_monitor i_mon (.i_clk, .i_resetn, .i_wr, .i_rd,
  .i_full_stop, .i_addr, .o_rdata, .o_loop_multiplier, .o_ref_divider, .o_ref_range_eff,
  .o_output_divider, .o_synth_div_eff, .o_ref_from_osc, .o_synth_clock_select,
  .o_can_osc_clk_en);
`default_nettype wire

// *** tb/psf_synth_status_tb_top.sv ***
// Register-level testbench of the synth status block
`timescale 1ns/100ps
`default_nettype none
module psf_synth_status_tb_top;
  logic       i_clk = 0, i_resetn = 0, i_poweron = 0, i_wr = 0, i_rd = 0, i_pseudo_stop = 0;
  logic       i_tick_event = 0, i_brownout_event = 0, i_bad_address_event = 0;
  logic       i_loop_in_tol = 1, i_osc_good = 1, i_full_stop = 0;
  logic [3:0] i_addr = 4'h0, o_ref_divider, o_irq_req;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic [5:0] o_loop_multiplier;
  logic [1:0] o_vco_range_sel, o_ref_range_eff;
  logic [4:0] o_output_divider;
  logic [6:0] o_synth_div_eff;
  logic       o_ref_from_osc, o_synth_clock_select, o_can_osc_clk_en;
  int         errors = 0, n_tests = 0, cycles = 0;
  psf_synth_status i_dut (.i_clk, .i_resetn, .i_poweron, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_tick_event, .i_brownout_event, .i_bad_address_event, .i_loop_in_tol,
    .i_osc_good, .i_full_stop, .i_pseudo_stop, .o_loop_multiplier, .o_vco_range_sel,
    .o_ref_divider, .o_ref_range_eff, .o_output_divider, .o_synth_div_eff, .o_ref_from_osc,
    .o_synth_clock_select, .o_can_osc_clk_en, .o_irq_req);
  // Free-running clock and a hang guard
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Write cycle, with event pulses in the same cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [2:0] ev);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    {i_tick_event, i_brownout_event, i_bad_address_event} <= ev;
    @(posedge i_clk);
    i_wr <= 1'b0;
    {i_tick_event, i_brownout_event, i_bad_address_event} <= 3'h0;
    #1;
  endtask
  // Read cycle; data stand in the following cycle only
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Map: 0 multiplier, 1 ref divider, 2 post divider, 3 flags, 4 control, 5 ratio
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(4'h4, 8'h02);
    rd(4'h2, 8'h03);
    rd(4'h5, 8'h02);
    rd(4'hF, 8'h00);
    @(posedge i_clk) i_poweron <= 1'b1;
    @(posedge i_clk) i_poweron <= 1'b0;
    rd(4'h3, 8'h7B);
    wr(4'h3, 8'hFF, 3'h0);
    rd(4'h3, 8'h09);
    wr(4'hF, 8'h00, 3'h7);
    wr(4'h3, 8'h00, 3'h0);
    rd(4'h3, 8'hAD);
    wr(4'h3, 8'hFF, 3'h4);
    rd(4'h3, 8'h89);
    wr(4'h3, 8'hFF, 3'h0);
    wr(4'h0, 8'h47, 3'h0);
    rd(4'h0, 8'h47);
    chk({2'h0, o_loop_multiplier}, 8'h07);
    chk({6'h0, o_vco_range_sel}, 8'h01);
    rd(4'h3, 8'h1B);
    wr(4'h4, 8'h03, 3'h0);
    wr(4'h0, 8'h11, 3'h0);
    rd(4'h0, 8'h47);
    wr(4'h1, 8'hF5, 3'h0);
    rd(4'h1, 8'h00);
    wr(4'h2, 8'h1F, 3'h0);
    rd(4'h2, 8'h1F);
    chk({3'h0, o_output_divider}, 8'h1F);
    chk({1'b0, o_synth_div_eff}, 8'h20);
    wr(4'h4, 8'h02, 3'h0);
    wr(4'h1, 8'hF5, 3'h0);
    rd(4'h1, 8'hC5);
    chk({4'h0, o_ref_divider}, 8'h05);
    chk({6'h0, o_ref_range_eff}, 8'h00);
    wr(4'h4, 8'hE4, 3'h0);
    wr(4'h2, 8'h01, 3'h0);
    rd(4'h2, 8'h1F);
    chk({6'h0, o_ref_range_eff}, 8'h03);
    chk({7'h0, o_ref_from_osc}, 8'h01);
    wr(4'h0, 8'h00, 3'h0);
    rd(4'h0, 8'h47);
    wr(4'hF, 8'h00, 3'h4);
    chk({4'h0, o_irq_req}, 8'h0E);
    @(posedge i_clk) i_loop_in_tol <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk({1'b0, o_synth_div_eff}, 8'h04);
    chk({7'h0, o_synth_clock_select}, 8'h01);
    @(posedge i_clk) i_loop_in_tol <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_full_stop <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({7'h0, o_can_osc_clk_en}, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
